// [shared/pet_consts.vh]
// Purpose: constants for the programmable event timer
// Assumes: included by the timer design file only
// Notes:   offsets and fields of the 96-bit timer memory word
`ifndef PET_CONSTS_VH
`define PET_CONSTS_VH

// ==================== memory geometry
`define PET_BANKS        4
`define PET_BANK_WORDS   32
`define PET_WORDS        128
`define PET_FIELD_W      32
// ==================== word layout, program/control/data
`define PET_PROG_HI      95
`define PET_PROG_LO      64
`define PET_CTRL_HI      63
`define PET_CTRL_LO      32
`define PET_DATA_HI      31
`define PET_DATA_LO      0
// ==================== program field
`define PET_OP_HI        31
`define PET_OP_LO        27
`define PET_PIN_HI       26
`define PET_PIN_LO       22
`define PET_ARG_BIT      21
// ==================== opcodes, 30 codes 0..29
`define PET_OP_NOP       5'h00
`define PET_OP_CNT       5'h01
`define PET_OP_ECMP      5'h02
`define PET_OP_PERIOD_COUNT_INSTR      5'h03
`define PET_OP_WIDTH_CAPTURE_INSTR      5'h04
`define PET_OP_END       5'h05
`define PET_OP_DOUT      5'h06
`define PET_OP_LAST      5'h1D
// ==================== counters and pins
`define PET_VCNT_W       25
`define PET_HWCNT_W      7
`define PET_PINS         32
`define PET_PIN_USED     32'h8003FFFF
`define PET_CMP_CH       31
// ==================== prescale fields
`define PET_HR_W         6
`define PET_LR_W         3
// ==================== pin-disable source select
`define PET_KSRC_GPIO    2'h0
`define PET_KSRC_ENC     2'h1
`endif

// [hw/pet_timer.v]
// Purpose: micro-sequenced event timer with capture, compare and pins
// Assumes: all inputs synchronous to sys_clk except encoderPhaseErr
// Notes:   program loads only while runEn is low
`timescale 1ns/1ns
`include "pet_consts.vh"

// ==================== per-pin input channel
module pet_pin_chan (
    // clock and reset
    input  wire                    sys_clk,
    input  wire                    rst,
    // pad and control
    input  wire                    padIn,
    input  wire [3:0]              filtLimit,
    input  wire                    loopStart,
    // results
    output reg                     levelReg,
    output reg                     riseReg,
    output reg                     fallReg,
    output reg  [`PET_HWCNT_W-1:0] stampReg
);
    reg [3:0]              filtCnt_reg;
    reg [`PET_HWCNT_W-1:0] hwCnt_reg;
    reg                    pendRise_reg;
    reg                    pendFall_reg;
    reg [`PET_HWCNT_W-1:0] pendStamp_reg;
    wire                   firstEdge = filtCnt_reg >= filtLimit &&
                                       padIn != levelReg &&
                                       !pendRise_reg && !pendFall_reg;

    // glitch filter: level must hold filtLimit+1 cycles
    always @(posedge sys_clk) begin
        if (rst) begin
            filtCnt_reg <= 4'h0;
            levelReg    <= 1'b0;
        end else if (padIn == levelReg) begin
            filtCnt_reg <= 4'h0;
        end else if (filtCnt_reg >= filtLimit) begin
            levelReg    <= padIn;
            filtCnt_reg <= 4'h0;
        end else begin
            filtCnt_reg <= filtCnt_reg + 4'h1;
        end
    end

    // hardware count within the loop, latched at first edge
    // a loop's edge is handed on at loop start so that an edge after
    // the capture opcode ran is not lost, at one loop of latency
    always @(posedge sys_clk) begin
        if (rst) begin
            hwCnt_reg     <= {`PET_HWCNT_W{1'b0}};
            pendRise_reg  <= 1'b0;
            pendFall_reg  <= 1'b0;
            pendStamp_reg <= {`PET_HWCNT_W{1'b0}};
            riseReg       <= 1'b0;
            fallReg       <= 1'b0;
            stampReg      <= {`PET_HWCNT_W{1'b0}};
        end else if (loopStart) begin
            hwCnt_reg     <= {`PET_HWCNT_W{1'b0}};
            riseReg       <= pendRise_reg | (firstEdge & padIn);
            fallReg       <= pendFall_reg | (firstEdge & ~padIn);
            stampReg      <= firstEdge ? hwCnt_reg : pendStamp_reg;
            pendRise_reg  <= 1'b0;
            pendFall_reg  <= 1'b0;
        end else begin
            if (hwCnt_reg != {`PET_HWCNT_W{1'b1}})
                hwCnt_reg <= hwCnt_reg + 7'h01; // saturate, no wrap
            if (firstEdge) begin
                pendRise_reg  <= padIn;
                pendFall_reg  <= ~padIn;
                pendStamp_reg <= hwCnt_reg;
            end
        end
    end
endmodule // pet_pin_chan

// ==================== timer top
module pet_timer (
    // clock and reset
    input  wire                    sys_clk,
    input  wire                    rst,
    // program load port
    input  wire                    runEn,
    input  wire                    hostWe,
    input  wire [6:0]              hostAddr,
    input  wire [95:0]             hostWdata,
    input  wire                    parityClr,
    // configuration
    input  wire [`PET_HR_W-1:0]    highResPrescale,
    input  wire [`PET_LR_W-1:0]    loopResPrescale,
    input  wire [3:0]              filtLimit,
    input  wire [31:0]             outDir,
    input  wire [31:0]             outputDisableSelect,
    input  wire [1:0]              pinMuxCtrl9,
    input  wire                    ch31Internal,
    // kill sources
    input  wire                    gpioABit5,
    input  wire                    encoderPhaseErr,
    // pins
    input  wire [31:0]             pinIn,
    output reg  [31:0]             pinOut,
    output reg  [31:0]             pinOe,
    // status and results
    output reg                     clkCmpSrc,
    output reg                     encoderErrOut,
    output reg                     parityErr,
    output reg                     badOpcode,
    output reg                     loopOverrun,
    output reg                     capValid,
    output reg  [4:0]              capPin,
    output reg  [31:0]             capValue
);
    // ==================== loop timing
    reg  [12:0] loopCnt_reg;
    reg  [`PET_VCNT_W-1:0] vTime_reg;
    wire [12:0] hrVal   = {7'h00, highResPrescale} + 13'h0001;
    wire [12:0] loopLen = hrVal << loopResPrescale;
    wire        loopStart = (loopCnt_reg == loopLen - 13'h0001);

    // loop length is (hr+1) shifted left by lr from the prescale fields
    always @(posedge sys_clk) begin
        if (rst || !runEn) begin
            loopCnt_reg <= 13'h0000;
            vTime_reg   <= {`PET_VCNT_W{1'b0}};
        end else if (loopStart) begin
            loopCnt_reg <= 13'h0000;
            vTime_reg   <= vTime_reg + 25'h0000001;
        end else begin
            loopCnt_reg <= loopCnt_reg + 13'h0001;
        end
    end

    // ==================== pin channels
    wire [31:0] lvl;
    wire [31:0] rise;
    wire [31:0] fall;
    wire [`PET_HWCNT_W*32-1:0] stamps;
    genvar g;
    generate
        for (g = 0; g < `PET_PINS; g = g + 1) begin : gChan
            pet_pin_chan uChan (
                .sys_clk   (sys_clk),
                .rst       (rst),
                .padIn     (pinIn[g]),
                .filtLimit (filtLimit),
                .loopStart (loopStart),
                .levelReg  (lvl[g]),
                .riseReg   (rise[g]),
                .fallReg   (fall[g]),
                .stampReg  (stamps[g*7 +: 7])
            );
        end
    endgenerate

    // ==================== banked dual-port memory
    reg         wrEn;
    reg  [6:0]  wrAddr;
    reg  [95:0] wrData;
    wire [6:0]  rdAddr;
    reg  [98:0] rdWord_reg;
    wire [98:0] bankOut [0:3];
    wire [2:0]  wrPar = {^wrData[95:64], ^wrData[63:32], ^wrData[31:0]};

    // four banks, each with its own write and read port
    generate
        for (g = 0; g < `PET_BANKS; g = g + 1) begin : gBank
            reg [98:0] mem [0:`PET_BANK_WORDS-1];
            reg [98:0] q_reg;
            always @(posedge sys_clk) begin
                if (wrEn && wrAddr[1:0] == g)
                    mem[wrAddr[6:2]] <= {wrPar, wrData};
                q_reg <= mem[rdAddr[6:2]];
            end
            assign bankOut[g] = q_reg;
        end
    endgenerate

    // ==================== sequencer
    reg  [6:0]  pc_reg;
    reg  [6:0]  exAddr_reg;
    reg  [1:0]  exBank_reg;
    reg         exValid_reg;
    reg         waitLoop_reg;
    reg         fwd_reg;
    reg  [95:0] fwdData_reg;
    wire        issue = runEn && !waitLoop_reg && !loopStart;
    assign rdAddr = pc_reg;

    // a read address equal to the write address takes forwarded data
    wire [98:0] rawWord = bankOut[exBank_reg];
    wire [95:0] word = fwd_reg ? fwdData_reg : rawWord[95:0];
    wire        parBad = !fwd_reg && exValid_reg &&
                         (rawWord[98:96] != {^rawWord[95:64],
                          ^rawWord[63:32], ^rawWord[31:0]});
    wire [4:0]  op  = word[`PET_PROG_LO+`PET_OP_HI:`PET_PROG_LO+`PET_OP_LO];
    wire [4:0]  pin = word[`PET_PROG_LO+`PET_PIN_HI:`PET_PROG_LO+`PET_PIN_LO];
    wire        arg = word[`PET_PROG_LO+`PET_ARG_BIT];
    wire [31:0] ctrl = word[`PET_CTRL_HI:`PET_CTRL_LO];
    wire [31:0] data = word[`PET_DATA_HI:`PET_DATA_LO];
    // 32-bit stamp is virtual time joined with pin count
    wire [31:0] stamp = {vTime_reg, stamps[pin*7 +: 7]};
    wire        edgeHit = arg ? rise[pin] : fall[pin];
    wire        exec = exValid_reg && !waitLoop_reg;

    // fetch: one read issued per cycle until an end opcode
    always @(posedge sys_clk) begin
        if (rst || !runEn) begin
            pc_reg       <= 7'h00;
            exValid_reg  <= 1'b0;
            waitLoop_reg <= 1'b0;
        end else if (loopStart) begin
            pc_reg       <= 7'h00;
            exValid_reg  <= 1'b0;
            waitLoop_reg <= 1'b0;
        end else begin
            exValid_reg <= issue;
            exAddr_reg  <= pc_reg;
            exBank_reg  <= pc_reg[1:0];
            if (issue)
                pc_reg <= pc_reg + 7'h01;
            // stop after end opcode or after the last word
            if ((exec && op == `PET_OP_END) || (issue && pc_reg == 7'h7F))
                waitLoop_reg <= 1'b1;
        end
    end

    // decode and execute; codes 7 to 29 act as no operation
    reg [31:0] pinOutNext;
    reg        capNext;
    reg [31:0] capValNext;
    always @* begin
        wrEn       = 1'b0;
        wrAddr     = exAddr_reg;
        wrData     = word;
        pinOutNext = pinOut;
        capNext    = 1'b0;
        capValNext = capValue;
        if (!runEn) begin
            wrEn   = hostWe;
            wrAddr = hostAddr;
            wrData = hostWdata;
        end else if (exec) begin
            case (op)
                `PET_OP_CNT: begin
                    // 25-bit virtual counter wraps at control value
                    wrEn = 1'b1;
                    if (data[24:0] >= ctrl[24:0])
                        wrData[24:0] = 25'h0000000;
                    else
                        wrData[24:0] = data[24:0] + 25'h0000001;
                end
                `PET_OP_ECMP: begin
                    if (vTime_reg == ctrl[24:0])
                        pinOutNext[pin] = arg;
                end
                `PET_OP_PERIOD_COUNT_INSTR: begin
                    // period valid only within source limits
                    if (edgeHit) begin
                        wrEn       = 1'b1;
                        wrData[31:0] = stamp;
                        capNext    = 1'b1;
                        capValNext = stamp - data;
                    end
                end
                `PET_OP_WIDTH_CAPTURE_INSTR: begin
                    // phase width assumed within source limits
                    if (edgeHit) begin
                        wrEn       = 1'b1;
                        wrData[31:0] = stamp;
                        capNext    = 1'b1;
                        capValNext = stamp;
                    end
                end
                `PET_OP_DOUT: pinOutNext[pin] = arg;
                default: ;
            endcase
        end
    end

    // result registers and sticky errors, set beats clear
    always @(posedge sys_clk) begin
        if (rst) begin
            fwd_reg     <= 1'b0;
            fwdData_reg <= 96'h0;
            pinOut      <= 32'h00000000;
            capValid    <= 1'b0;
            capPin      <= 5'h00;
            capValue    <= 32'h00000000;
            parityErr   <= 1'b0;
            badOpcode   <= 1'b0;
            loopOverrun <= 1'b0;
        end else begin
            fwd_reg     <= wrEn && wrAddr == rdAddr;
            fwdData_reg <= wrData;
            pinOut      <= pinOutNext;
            capValid    <= capNext;
            capPin      <= capNext ? pin : capPin;
            capValue    <= capValNext;
            // parity failure is sticky until cleared
            parityErr   <= parBad | (parityErr & ~parityClr);
            badOpcode   <= (exec && op > `PET_OP_LAST) |
                           (badOpcode & ~parityClr);
            loopOverrun <= (runEn && loopStart && !waitLoop_reg) |
                           (loopOverrun & ~parityClr);
        end
    end

    // ==================== pin disable and comparator feed
    reg  encSync1_reg;
    reg  encSync2_reg;
    reg  killN;
    always @(posedge sys_clk) begin
        if (rst) begin
            encSync1_reg <= 1'b1;
            encSync2_reg <= 1'b1;
        end else begin
            encSync1_reg <= ~encoderPhaseErr;
            encSync2_reg <= encSync1_reg;
        end
    end

    // source select; other codes leave outputs enabled
    always @* begin
        case (pinMuxCtrl9)
            // gpio level straight from its input buffer
            `PET_KSRC_GPIO: killN = gpioABit5;
            `PET_KSRC_ENC:  killN = encSync2_reg;
            default:        killN = 1'b1;
        endcase
    end

    // only selected outputs float while kill is low
    wire [31:0] oeNext = outDir & `PET_PIN_USED &
                         ~(outputDisableSelect & {32{~killN}}) &
                         ~({ch31Internal, 31'h0});
    always @(posedge sys_clk) begin
        if (rst) begin
            pinOe         <= 32'h00000000;
            clkCmpSrc     <= 1'b0;
            encoderErrOut <= 1'b0;
        end else begin
            // only the bonded nineteen pins may drive
            pinOe         <= oeNext;
            // comparator taken before the pad buffer
            clkCmpSrc     <= pinOutNext[`PET_CMP_CH];
            encoderErrOut <= encoderPhaseErr;
        end
    end
endmodule // pet_timer

// [tb/pet_sensor_model.sv]
// Purpose: sensor square wave on timer pad 2
// Assumes: pads without a driver are pulled low
// Notes:   half period is counted in sys_clk cycles
`timescale 1ns/1ns
module pet_sensor_model (
    // clock and control
    input  wire        sys_clk,
    input  wire        sensEn,
    input  wire [7:0]  halfPeriod,
    // pads seen by the timer
    output reg  [31:0] padDrive
);
    reg [7:0] phaseReg;
    initial begin
        padDrive = 32'h0;
        phaseReg = 8'h0;
    end
    // ====================
    // period and phase kept long
    always @(posedge sys_clk) begin
        if (!sensEn) begin
            phaseReg <= 8'h0;
            padDrive <= 32'h0;
        end else if (phaseReg == halfPeriod - 8'h1) begin
            phaseReg    <= 8'h0;
            padDrive[2] <= ~padDrive[2];
        end else begin
            phaseReg <= phaseReg + 8'h1;
        end
    end
endmodule // pet_sensor_model

// [tb/pet_timer_checker.sv]
// Purpose: port assertions for the event timer
// Assumes: one clock domain, rst synchronous high
// Notes:   gpio kill takes one cycle, encoder kill three
`timescale 1ns/1ns
module pet_timer_checker (
    // clock and reset
    input wire        sys_clk,
    input wire        rst,
    // configuration and kill sources
    input wire [31:0] outDir,
    input wire [31:0] outputDisableSelect,
    input wire [1:0]  pinMuxCtrl9,
    input wire        ch31Internal,
    input wire        gpioABit5,
    input wire        encoderPhaseErr,
    input wire        parityClr,
    // observed outputs
    input wire [31:0] pinOut,
    input wire [31:0] pinOe,
    input wire        clkCmpSrc,
    input wire        encoderErrOut,
    input wire        badOpcode
);
    // ====================
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // bit 31 left out: it may be internal only
    localparam [31:0] LOW_PINS = 32'h0003FFFF;
    wire [31:0] killedOe = pinOe & outputDisableSelect;
    // encoder error rises while something can be floated
    sequence encRise;
        $rose(encoderPhaseErr) && pinMuxCtrl9 == 2'h1 && killedOe != 32'h0;
    endsequence
    // two synchroniser cycles, then the float
    sequence encFloat;
        killedOe != 32'h0 ##1 killedOe != 32'h0 ##1 killedOe == 32'h0;
    endsequence
    a_kill_floats_sel: assert property (
        pinMuxCtrl9 == 2'h0 && !gpioABit5 |=> killedOe == 32'h0)
        else $error("selected output still driven under kill");
    a_no_kill_drive: assert property (
        (pinMuxCtrl9 == 2'h0 && gpioABit5) || pinMuxCtrl9[1] |=>
        pinOe == ($past(outDir) & 32'h8003FFFF & ~{$past(ch31Internal), 31'h0}))
        else $error("output enable wrong without kill");
    a_unsel_ignore: assert property (
        1'b1 |=> (pinOe & ~$past(outputDisableSelect) & LOW_PINS) ==
        ($past(outDir) & ~$past(outputDisableSelect) & LOW_PINS))
        else $error("unselected output changed");
    a_enc_kill_sync: assert property (encRise |=> encFloat)
        else $error("encoder kill latency wrong");
    a_enc_err_follow: assert property (
        1'b1 |=> encoderErrOut == $past(encoderPhaseErr))
        else $error("encoder error output not following");
    a_ch31_internal: assert property (ch31Internal |=> !pinOe[31])
        else $error("channel 31 drives pad while internal");
    a_cmp_follows: assert property (clkCmpSrc == pinOut[31])
        else $error("comparator source differs from channel 31");
    a_opcode_sticky: assert property (
        badOpcode && !parityClr |=> badOpcode)
        else $error("bad opcode flag dropped");
endmodule // pet_timer_checker

bind pet_timer pet_timer_checker u_chk (
    .sys_clk, .rst, .outDir, .outputDisableSelect, .pinMuxCtrl9,
    .ch31Internal, .gpioABit5, .encoderPhaseErr, .parityClr, .pinOut,
    .pinOe, .clkCmpSrc, .encoderErrOut, .badOpcode
);

// [tb/test_programmable_event_timer_pins.sv]
// Purpose: self-checking bench for the event timer
// Assumes: sensor model drives pad 2
// Notes:   all inputs but pinIn change 1 ns after the rising edge; the sensor model drives pinIn on the edge
`timescale 1ns/1ns
module test_programmable_event_timer_pins;
    // ====================
    reg         sys_clk, rst, runEn, hostWe, parityClr, sensEn;
    reg         ch31Internal, gpioABit5, encoderPhaseErr;
    reg  [6:0]  hostAddr;
    reg  [95:0] hostWdata;
    reg  [5:0]  highResPrescale;
    reg  [2:0]  loopResPrescale;
    reg  [3:0]  filtLimit;
    reg  [31:0] outDir, outputDisableSelect;
    reg  [1:0]  pinMuxCtrl9;
    wire [31:0] pinIn, pinOut, pinOe, capValue;
    wire [4:0]  capPin;
    wire        clkCmpSrc, encoderErrOut, parityErr, badOpcode;
    wire        loopOverrun, capValid;
    integer     numErrors, samplesChecked;

    pet_timer DUT (
        .sys_clk, .rst, .runEn, .hostWe, .hostAddr, .hostWdata, .parityClr,
        .highResPrescale, .loopResPrescale, .filtLimit, .outDir,
        .outputDisableSelect, .pinMuxCtrl9, .ch31Internal, .gpioABit5,
        .encoderPhaseErr, .pinIn, .pinOut, .pinOe, .clkCmpSrc,
        .encoderErrOut, .parityErr, .badOpcode, .loopOverrun, .capValid,
        .capPin, .capValue
    );
    pet_sensor_model sensor (
        .sys_clk, .sensEn, .halfPeriod(8'h08), .padDrive(pinIn)
    );

    // ==================== helpers
    function [95:0] pw(input [4:0] op, input [4:0] pin, input arg);
        pw = {op, pin, arg, 85'h0};
    endfunction
    task tick(input integer n);
        begin
            repeat (n) @(posedge sys_clk);
            #1;
        end
    endtask
    task check(input string what, input [31:0] seen, input [31:0] exp);
        begin
            samplesChecked = samplesChecked + 1;
            if (seen !== exp) begin
                numErrors = numErrors + 1;
                $display("MISMATCH %0s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    task wr(input [6:0] a, input [95:0] d);
        begin
            hostWe = 1'b1;
            hostAddr = a;
            hostWdata = d;
            tick(1);
        end
    endtask
    // stop, load two words and END, restart the sequencer
    task prog(input [95:0] w0, input [95:0] w1);
        begin
            runEn = 1'b0;
            wr(7'h00, w0);
            wr(7'h01, w1);
            wr(7'h02, pw(5'h05, 5'h00, 1'b0));
            hostWe = 1'b0;
            runEn = 1'b1;
        end
    endtask
    task stop_test;
        begin
            if (numErrors == 0 && samplesChecked > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask

    // ==================== scenarios
    // pads driven, then floated by each kill source
    task test_pins;
        begin
            prog(pw(5'h06, 5'h00, 1'b1), pw(5'h06, 5'h1F, 1'b1));
            tick(8);
            check("pinOe", pinOe, 32'h8003FFFF);
            check("pinOut", pinOut & 32'h80000001, 32'h80000001);
            check("clkCmpSrc", {31'h0, clkCmpSrc}, 32'h1);
            gpioABit5 = 1'b0;
            tick(2);
            check("pinOe", pinOe, 32'h8003FFF0);
            pinMuxCtrl9 = 2'h2;
            tick(2);
            check("pinOe", pinOe, 32'h8003FFFF);
            pinMuxCtrl9 = 2'h1;
            tick(4);
            check("pinOe", pinOe, 32'h8003FFFF);
            encoderPhaseErr = 1'b1;
            tick(1);
            check("encoderErrOut", {31'h0, encoderErrOut}, 32'h1);
            tick(3);
            check("pinOe", pinOe, 32'h8003FFF0);
            encoderPhaseErr = 1'b0;
            pinMuxCtrl9 = 2'h0;
            gpioABit5 = 1'b1;
            ch31Internal = 1'b1;
            tick(4);
            check("pinOe", pinOe, 32'h0003FFFF);
            check("clkCmpSrc", {31'h0, clkCmpSrc}, 32'h1);
            ch31Internal = 1'b0;
        end
    endtask
    // last legal opcode and both illegal ones
    task test_opcodes;
        integer op;
        begin
            for (op = 29; op < 32; op = op + 1) begin
                prog(pw(op[4:0], 5'h00, 1'b0), pw(5'h00, 5'h00, 1'b0));
                tick(6);
                check("badOpcode", {31'h0, badOpcode}, {31'h0, op > 29});
                runEn = 1'b0;
                tick(2);
                parityClr = 1'b1;
                tick(1);
                parityClr = 1'b0;
                tick(1);
                check("badOpcode", {31'h0, badOpcode}, 32'h0);
            end
        end
    endtask
    // period count on pad 2, delta in stamp units, 128 per loop
    task test_capture(input [5:0] hr, input [2:0] lr, input [31:0] delta);
        integer i, n;
        begin
            runEn = 1'b0;
            highResPrescale = hr;
            loopResPrescale = lr;
            prog(pw(5'h03, 5'h02, 1'b1), pw(5'h00, 5'h00, 1'b0));
            sensEn = 1'b1;
            for (i = 0; i < 3; i = i + 1) begin
                n = 0;
                while (capValid !== 1'b1 && n < 100) begin
                    tick(1);
                    n = n + 1;
                end
                check("capValid", {31'h0, capValid}, 32'h1);
                check("capPin", {27'h0, capPin}, 32'h2);
                if (i > 0)
                    check("capValue", capValue, delta);
                tick(1);
            end
            sensEn = 1'b0;
        end
    endtask

    // ==================== clock, watchdog, main sequence
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    initial begin
        #100000;
        numErrors = numErrors + 1;
        stop_test;
    end
    initial begin
        {rst, runEn, hostWe, hostAddr, hostWdata, parityClr} = {1'b1, 106'h0};
        {sensEn, ch31Internal, encoderPhaseErr, pinMuxCtrl9} = 5'h0;
        gpioABit5 = 1'b1;
        highResPrescale = 6'h01;
        loopResPrescale = 3'h2;
        filtLimit = 4'h0;
        outDir = 32'hFFFFFFFF;
        outputDisableSelect = 32'h0000000F;
        numErrors = 0;
        samplesChecked = 0;
        tick(2);
        rst = 1'b0;
        test_pins;
        test_opcodes;
        test_capture(6'h01, 3'h2, 32'h00000100);
        test_capture(6'h00, 3'h2, 32'h00000200);
        stop_test;
    end
endmodule // test_programmable_event_timer_pins
